// File: lprtc_pkg.sv
// Purpose: Constants for the low power real-time counter block
// Assumes: APB with 32-bit data, byte addresses, pclk at 20 MHz
// Notes:   Offsets are byte addresses of aligned words
package lprtc_pkg;
    // Widths
    localparam int CNT_W  = 24;                        // Counter width
    localparam int DIV_W  = 12;                        // Divider width
    localparam int NUM_CH = 4;                         // Compare channels
    localparam int NUM_EV = 6;                         // Tick, wrap, four compares
    // Task registers
    localparam logic [11:0] OFS_TASK_START = 12'h000;  // Start counting
    localparam logic [11:0] OFS_TASK_STOP  = 12'h004;  // Stop counting
    localparam logic [11:0] OFS_TASK_CLEAR = 12'h008;  // Clear counter
    localparam logic [11:0] OFS_TASK_NEAR  = 12'h00C;  // Force near wrap
    // Event registers
    localparam logic [11:0] OFS_EV_TICK    = 12'h100;  // Tick event flag
    localparam logic [11:0] OFS_EV_WRAP    = 12'h104;  // Wrap event flag
    localparam logic [11:0] OFS_EV_CMP0    = 12'h140;  // Compare flag 0, step 4
    // Routing registers
    localparam logic [11:0] OFS_ROUTE      = 12'h340;  // Route enable, plain write
    localparam logic [11:0] OFS_ROUTE_SET  = 12'h344;  // Write one to set
    localparam logic [11:0] OFS_ROUTE_CLR  = 12'h348;  // Write one to clear
    // Data registers
    localparam logic [11:0] OFS_COUNT      = 12'h504;  // Captured count
    localparam logic [11:0] OFS_DIVIDER    = 12'h508;  // Divider setting
    localparam logic [11:0] OFS_MATCH0     = 12'h540;  // Match value 0, step 4
    localparam logic [11:0] OFS_STATUS     = 12'h600;  // Running flag
    // Event bit positions
    localparam int EV_TICK = 0;                        // Tick bit
    localparam int EV_WRAP = 1;                        // Wrap bit
    localparam int EV_CMP  = 2;                        // First compare bit
    // Values
    localparam logic [23:0] NEAR_WRAP_VALUE = 24'hFF_FFF0; // Load on force task
    localparam logic [23:0] CNT_MAX         = 24'hFF_FFFF; // Last count before wrap
    localparam logic [1:0]  COUNT_WAIT      = 2'h3;    // Stall cycles on count read
    // Slow clock frequency for reference
    localparam real SLOW_CLOCK_KHZ = 32.768;           // Nominal slow clock
    // Bus state
    typedef enum logic [0:0] {
        LPRTC_BUS_IDLE = 1'b0,                         // No count read pending
        LPRTC_BUS_WAIT = 1'b1                          // Count read stalling
    } lprtc_bus_t;
endpackage

// File: lprtc_core.sv
// Purpose: Real-time counter with divider, compare, tick and wrap events
// Assumes: slow_clock is an input sampled on pclk and much slower than pclk
// Notes:   Tasks act on synchronised slow clock edges; all logic runs on pclk
//
// Notes on behaviour
// - 24-bit counter, 12-bit divider, compares, tick
// - Rate is slow clock over divider plus one
// - Divider writes ignored while running
// - Start, clear, near-wrap reload divider latch
// - Increment when latch zero, then reload latch
// - Tick on increment, disabled after reset
// - Near-wrap task loads 0xFFFFF0
// - Wrap event on 0xFFFFFF to zero
// - Disabled event requests no fast clock
// - Clear with match zero gives no compare
// - Start at match value gives no compare
// - Compare on step from match-1 to match
// - Match N+2 written at N always fires
// - Old match far ahead never fires
// - Count captured on read, controls synchronised
// - Clear, stop, near-wrap wait fall then rise
// - First increment divider plus one slow periods after start
// - Near-wrap starts slow clock, loads once clocked
// - Count read stalls three cycles, five total
// - Route set register sets, reads enable state
`timescale 1ns/1ps
module lprtc_core (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Slow clock and clock requests
    input  wire logic        slow_clock,
    output logic             slow_clock_request,
    output logic             fast_clock_request,
    // Routed event pulses
    output logic      [5:0]  event_pulse
);
    // Synchroniser and edge history
    logic sync1_reg, sync2_reg, sync3_reg;             // Slow clock pipeline
    logic rise, fall;                                  // Slow clock edges
    // Control state
    logic        running_reg, running_next;            // Counter running
    logic [23:0] count_reg, count_next;                // Slow domain counter
    logic [11:0] divider_reg, divider_next;            // Programmed divider
    logic [11:0] divider_latch_reg, divider_latch_next;// Internal divider latch
    logic        pend_start_reg, pend_start_next;      // Start waiting
    logic        pend_stop_reg, pend_stop_next;        // Stop waiting
    logic        pend_clear_reg, pend_clear_next;      // Clear waiting
    logic        pend_near_reg, pend_near_next;        // Near wrap waiting
    logic        armed_reg, armed_next;                // Falling edge seen
    logic [23:0] match_reg [4], match_next [4];        // Match values
    logic [5:0]  flag_reg, flag_next;                  // Sticky event flags
    logic [5:0]  route_reg, route_next;                // Event routing enables
    logic [5:0]  pulse_reg, pulse_next;                // Routed event pulses
    logic        fast_req_reg, fast_req_next;          // Fast clock request
    // Bus state
    lprtc_pkg::lprtc_bus_t bus_reg, bus_next;          // Count read state
    logic [1:0]  wait_reg, wait_next;                  // Stall counter
    logic [23:0] snap_reg, snap_next;                  // Captured count
    logic [31:0] rdata_reg, rdata_next;                // Read data register
    // Decode helpers
    logic        wr, rd_count, access;                 // Bus strobes
    logic [5:0]  raw_ev;                               // Events before routing
    logic        inc;                                  // Counter increments now

    // Slow clock synchroniser; first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
        end else begin
            sync1_reg <= slow_clock;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // Edges of the synchronised slow clock
    assign rise = sync2_reg & ~sync3_reg;
    assign fall = ~sync2_reg & sync3_reg;

    // Bus strobes
    assign access   = psel & penable;
    assign wr       = access & pwrite & pready;
    assign rd_count = psel & ~pwrite & (paddr == lprtc_pkg::OFS_COUNT);

    // Counter, tasks, events and registers
    always_comb begin
        running_next       = running_reg;
        count_next         = count_reg;
        divider_next       = divider_reg;
        divider_latch_next = divider_latch_reg;
        pend_start_next    = pend_start_reg;
        pend_stop_next     = pend_stop_reg;
        pend_clear_next    = pend_clear_reg;
        pend_near_next     = pend_near_reg;
        armed_next         = armed_reg;
        for (int i = 0; i < lprtc_pkg::NUM_CH; i++) begin
            match_next[i] = match_reg[i];
        end
        route_next = route_reg;
        raw_ev     = 6'h00;
        inc        = 1'b0;
        // Falling edge arms the delayed tasks
        if (fall && (pend_stop_reg || pend_clear_reg || pend_near_reg)) begin
            armed_next = 1'b1;
        end
        // Rising edge: apply tasks, or else count
        if (rise) begin
            if (pend_start_reg) begin
                running_next       = 1'b1;
                divider_latch_next = divider_reg;
                pend_start_next    = 1'b0;
            end
            if (armed_reg) begin
                armed_next = 1'b0;
                if (pend_clear_reg) begin
                    count_next         = 24'h00_0000;
                    divider_latch_next = divider_reg;
                end
                if (pend_near_reg) begin
                    count_next         = lprtc_pkg::NEAR_WRAP_VALUE;
                    divider_latch_next = divider_reg;
                end
                if (pend_stop_reg) begin
                    running_next = 1'b0;
                end
                pend_clear_next = 1'b0;
                pend_near_next  = 1'b0;
                pend_stop_next  = 1'b0;
            end else if (running_reg && !pend_start_reg) begin
                if (divider_latch_reg == 12'h000) begin
                    inc                = 1'b1;
                    count_next         = count_reg + 24'h00_0001;
                    divider_latch_next = divider_reg;
                end else begin
                    divider_latch_next = divider_latch_reg - 12'h001;
                end
            end
        end
        // Events only on a real increment; loads and start never compare
        if (inc) begin
            raw_ev[lprtc_pkg::EV_TICK] = 1'b1;
            raw_ev[lprtc_pkg::EV_WRAP] = (count_reg == lprtc_pkg::CNT_MAX);
            for (int i = 0; i < lprtc_pkg::NUM_CH; i++) begin
                raw_ev[lprtc_pkg::EV_CMP + i] = (count_next == match_reg[i]);
            end
        end
        // Register writes
        if (wr) begin
            unique case (paddr)
                lprtc_pkg::OFS_TASK_START: begin
                    if (pwdata[0]) pend_start_next = 1'b1;
                end
                lprtc_pkg::OFS_TASK_STOP: begin
                    if (pwdata[0]) pend_stop_next = 1'b1;
                end
                lprtc_pkg::OFS_TASK_CLEAR: begin
                    if (pwdata[0]) pend_clear_next = 1'b1;
                end
                lprtc_pkg::OFS_TASK_NEAR: begin
                    if (pwdata[0]) pend_near_next = 1'b1;
                end
                lprtc_pkg::OFS_ROUTE: begin
                    route_next = pwdata[5:0];
                end
                lprtc_pkg::OFS_ROUTE_SET: begin
                    route_next = route_reg | pwdata[5:0];
                end
                lprtc_pkg::OFS_ROUTE_CLR: begin
                    route_next = route_reg & ~pwdata[5:0];
                end
                lprtc_pkg::OFS_DIVIDER: begin
                    if (!running_reg && !pend_start_reg) begin
                        divider_next = pwdata[11:0];
                    end
                end
                default: begin
                    for (int i = 0; i < lprtc_pkg::NUM_CH; i++) begin
                        if (paddr == lprtc_pkg::OFS_MATCH0 + 12'(4 * i)) begin
                            match_next[i] = pwdata[23:0];
                        end
                    end
                end
            endcase
        end
    end

    // Event flags: clear by writing zero, a new event wins
    always_comb begin
        flag_next     = flag_reg;
        pulse_next    = raw_ev & route_reg;
        fast_req_next = |(raw_ev & route_reg);
        if (wr && paddr == lprtc_pkg::OFS_EV_TICK && !pwdata[0]) begin
            flag_next[lprtc_pkg::EV_TICK] = 1'b0;
        end
        if (wr && paddr == lprtc_pkg::OFS_EV_WRAP && !pwdata[0]) begin
            flag_next[lprtc_pkg::EV_WRAP] = 1'b0;
        end
        for (int i = 0; i < lprtc_pkg::NUM_CH; i++) begin
            if (wr && paddr == lprtc_pkg::OFS_EV_CMP0 + 12'(4 * i) && !pwdata[0]) begin
                flag_next[lprtc_pkg::EV_CMP + i] = 1'b0;
            end
        end
        flag_next = flag_next | (raw_ev & route_reg);
    end

    // Bus: count reads capture the count and stall three cycles
    always_comb begin
        bus_next   = bus_reg;
        wait_next  = wait_reg;
        snap_next  = snap_reg;
        rdata_next = rdata_reg;
        pready     = 1'b1;
        unique case (bus_reg)
            lprtc_pkg::LPRTC_BUS_IDLE: begin
                if (rd_count && !penable) begin
                    bus_next  = lprtc_pkg::LPRTC_BUS_WAIT;
                    wait_next = lprtc_pkg::COUNT_WAIT;
                    snap_next = count_reg;
                end
            end
            lprtc_pkg::LPRTC_BUS_WAIT: begin
                pready = (wait_reg == 2'h0);
                if (access && wait_reg != 2'h0) begin
                    wait_next = wait_reg - 2'h1;
                end
                if (access && wait_reg == 2'h0) begin
                    bus_next = lprtc_pkg::LPRTC_BUS_IDLE;
                end
            end
        endcase
        // Read data for the next cycle
        if (psel && !pwrite) begin
            rdata_next = 32'h0000_0000;
            unique case (paddr)
                lprtc_pkg::OFS_EV_TICK:   rdata_next[0]    = flag_reg[lprtc_pkg::EV_TICK];
                lprtc_pkg::OFS_EV_WRAP:   rdata_next[0]    = flag_reg[lprtc_pkg::EV_WRAP];
                lprtc_pkg::OFS_ROUTE:     rdata_next[5:0]  = route_reg;
                lprtc_pkg::OFS_ROUTE_SET: rdata_next[5:0]  = route_reg;
                lprtc_pkg::OFS_ROUTE_CLR: rdata_next[5:0]  = route_reg;
                lprtc_pkg::OFS_COUNT:     rdata_next[23:0] = snap_next;
                lprtc_pkg::OFS_DIVIDER:   rdata_next[11:0] = divider_reg;
                lprtc_pkg::OFS_STATUS:    rdata_next[0]    = running_reg;
                default: begin
                    for (int i = 0; i < lprtc_pkg::NUM_CH; i++) begin
                        if (paddr == lprtc_pkg::OFS_EV_CMP0 + 12'(4 * i)) begin
                            rdata_next[0] = flag_reg[lprtc_pkg::EV_CMP + i];
                        end
                        if (paddr == lprtc_pkg::OFS_MATCH0 + 12'(4 * i)) begin
                            rdata_next[23:0] = match_reg[i];
                        end
                    end
                end
            endcase
        end
    end

    // State registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            running_reg       <= 1'b0;
            count_reg         <= 24'h00_0000;
            divider_reg       <= 12'h000;
            divider_latch_reg <= 12'h000;
            pend_start_reg    <= 1'b0;
            pend_stop_reg     <= 1'b0;
            pend_clear_reg    <= 1'b0;
            pend_near_reg     <= 1'b0;
            armed_reg         <= 1'b0;
            for (int i = 0; i < lprtc_pkg::NUM_CH; i++) begin
                match_reg[i] <= 24'h00_0000;
            end
            flag_reg     <= 6'h00;
            route_reg    <= 6'h00;
            pulse_reg    <= 6'h00;
            fast_req_reg <= 1'b0;
            bus_reg      <= lprtc_pkg::LPRTC_BUS_IDLE;
            wait_reg     <= 2'h0;
            snap_reg     <= 24'h00_0000;
            rdata_reg    <= 32'h0000_0000;
        end else begin
            running_reg       <= running_next;
            count_reg         <= count_next;
            divider_reg       <= divider_next;
            divider_latch_reg <= divider_latch_next;
            pend_start_reg    <= pend_start_next;
            pend_stop_reg     <= pend_stop_next;
            pend_clear_reg    <= pend_clear_next;
            pend_near_reg     <= pend_near_next;
            armed_reg         <= armed_next;
            for (int i = 0; i < lprtc_pkg::NUM_CH; i++) begin
                match_reg[i] <= match_next[i];
            end
            flag_reg     <= flag_next;
            route_reg    <= route_next;
            pulse_reg    <= pulse_next;
            fast_req_reg <= fast_req_next;
            bus_reg      <= bus_next;
            wait_reg     <= wait_next;
            snap_reg     <= snap_next;
            rdata_reg    <= rdata_next;
        end
    end

    // Outputs
    assign prdata             = rdata_reg;
    assign pslverr            = 1'b0;
    assign event_pulse        = pulse_reg;
    assign fast_clock_request = fast_req_reg;
    // Keep slow clock asked for while running or a task waits
    assign slow_clock_request = running_reg | pend_start_reg | pend_stop_reg
                              | pend_clear_reg | pend_near_reg;
endmodule

// File: lprtc_monitor.sv
// Purpose: Port checks on the counter block, bus timing and event pulses
// Assumes: One pclk domain, presetn asynchronous and active low
// Notes:   Bound to every lprtc_core instance
`timescale 1ns/1ps
module lprtc_monitor (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Clock requests and events
    input wire logic        slow_clock,
    input wire logic        slow_clock_request,
    input wire logic        fast_clock_request,
    input wire logic [5:0]  event_pulse
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Setup cycle and taken task write
    wire logic setup = psel && !penable;
    wire logic task_wr = psel && penable && pready && pwrite && pwdata[0];

    a_idle_ready: assert property (!psel |-> pready) else $error("pready low outside a transfer");
    a_count_stall: assert property (setup && !pwrite && paddr == lprtc_pkg::OFS_COUNT
        |=> !pready [*3] ##1 pready) else $error("count read not five cycles");
    a_quick_ready: assert property (setup && (pwrite || paddr != lprtc_pkg::OFS_COUNT)
        |=> pready) else $error("plain transfer stalled");
    a_no_error: assert property (!pslverr) else $error("pslverr raised");
    a_read_hold: assert property ($changed(prdata) |-> $past(psel && !pwrite))
        else $error("prdata moved without a read");
    a_fast_route: assert property (fast_clock_request == (|event_pulse))
        else $error("fast clock request not tied to routed events");
    a_tick_run: assert property (event_pulse[lprtc_pkg::EV_TICK] |-> slow_clock_request)
        else $error("tick while idle");
    a_near_req: assert property (task_wr && paddr == lprtc_pkg::OFS_TASK_NEAR
        |=> slow_clock_request [*2]) else $error("near wrap task did not request slow clock");
    a_start_req: assert property (task_wr && paddr == lprtc_pkg::OFS_TASK_START
        |=> slow_clock_request) else $error("start task did not request slow clock");
endmodule

bind lprtc_core lprtc_monitor u_lprtc_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .slow_clock(slow_clock), .slow_clock_request(slow_clock_request),
    .fast_clock_request(fast_clock_request), .event_pulse(event_pulse));

// File: lprtc_slow_src.sv
// Purpose: Slow clock source that runs only while the block asks for it
// Assumes: Half period in ns, phase kept away from pclk edges
// Notes:   Parks low whenever no request is present
`timescale 1ns/1ps
module lprtc_slow_src #(
    parameter int HALF_NS = 15259  // Half period of the slow clock
) (
    // Request from the block
    input  wire logic request,
    // Generated clock
    output logic      slow_clock
);
    // Oscillator: toggles while requested, stands low otherwise
    initial begin
        slow_clock = 1'b0;
        #17;
        forever begin
            #HALF_NS;
            slow_clock = request ? ~slow_clock : 1'b0;
        end
    end
endmodule

// File: tb_low_power_real_time_counter.sv
// Purpose: Self-checking bench for the low power real-time counter
// Assumes: Slow clock from the partner model at a shortened period
// Notes:   One slow period is 16 pclk cycles here
`timescale 1ns/1ps
module tb_low_power_real_time_counter;
    // APB drive and reset
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    // Block outputs
    logic [31:0] prdata;
    logic        pready;
    logic        slow_clock;
    logic        slow_req;
    logic        fast_req;
    logic [5:0]  event_pulse;
    // Scoreboard state
    int          err_count  = 0;
    int          n_tests    = 0;
    int          cyc        = 0;
    int          ev_cnt [6] = '{default: 0};
    logic [31:0] rd;
    int          n0;
    int          f0;
    int          fr_cnt     = 0;

    // Clock
    always #25 pclk = ~pclk;

    // Cycle and event pulse counters
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        for (int i = 0; i < 6; i++) begin
            if (event_pulse[i] === 1'b1) begin
                ev_cnt[i] <= ev_cnt[i] + 1;
            end
        end
        if (fast_req === 1'b1) begin
            fr_cnt <= fr_cnt + 1;
        end
    end

    lprtc_core u_lprtc_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
        .slow_clock(slow_clock), .slow_clock_request(slow_req), .fast_clock_request(fast_req),
        .event_pulse(event_pulse));
    lprtc_slow_src #(.HALF_NS(400)) u_lprtc_slow_src (.request(slow_req), .slow_clock(slow_clock));

    // Verdict and end of run
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Compare one value
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Hang cut short
    task automatic give_up(input string what);
        err_count++;
        $display("ERROR %s expected done seen timeout", what);
        finish_test();
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        int k;
        k = 0;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 20) begin
            k++;
            @(posedge pclk);
        end
        if (k >= 20) give_up("pready");
        q = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd);
    endtask
    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, rd);
        chk(what, rd, exp);
    endtask
    // Read until a value shows, bounded
    task automatic poll(input string what, input logic [11:0] a, input logic [31:0] exp);
        int k;
        k = 0;
        do begin
            apb(1'b0, a, 32'h0000_0000, rd);
            k++;
        end while (rd !== exp && k < 30);
        chk(what, rd, exp);
    endtask
    // Wait for an event count, bounded
    task automatic wait_ev(input int b, input int target, input int limit);
        int k;
        k = 0;
        while (ev_cnt[b] < target && k < limit) begin
            k++;
            @(posedge pclk);
        end
        if (k >= limit) give_up("event pulse");
    endtask

    // Reset values and unmapped space
    task automatic t_reset();
        rd_chk("route", lprtc_pkg::OFS_ROUTE, 32'h0000_0000);
        rd_chk("divider", lprtc_pkg::OFS_DIVIDER, 32'h0000_0000);
        rd_chk("count", lprtc_pkg::OFS_COUNT, 32'h0000_0000);
        wr(12'h7F0, 32'hFFFF_FFFF);
        rd_chk("unmapped", 12'h7F0, 32'h0000_0000);
    endtask
    // Route set and clear registers
    task automatic t_route();
        wr(lprtc_pkg::OFS_ROUTE, 32'h0000_0012);
        rd_chk("route plain", lprtc_pkg::OFS_ROUTE_CLR, 32'h0000_0012);
        wr(lprtc_pkg::OFS_ROUTE_SET, 32'h0000_003F);
        rd_chk("route set", lprtc_pkg::OFS_ROUTE_SET, 32'h0000_003F);
        wr(lprtc_pkg::OFS_ROUTE_CLR, 32'h0000_0020);
        rd_chk("route", lprtc_pkg::OFS_ROUTE, 32'h0000_001F);
    endtask
    // Divider width, rate, and lock while running
    task automatic t_rate();
        wr(lprtc_pkg::OFS_DIVIDER, 32'h0000_F001);
        rd_chk("divider", lprtc_pkg::OFS_DIVIDER, 32'h0000_0001);
        wr(lprtc_pkg::OFS_TASK_START, 32'h0000_0001);
        wait_ev(lprtc_pkg::EV_TICK, ev_cnt[0] + 1, 200);
        n0 = cyc;
        f0 = fr_cnt;
        wait_ev(lprtc_pkg::EV_TICK, ev_cnt[0] + 1, 100);
        chk("tick spacing", cyc - n0, 32);
        chk("fast request", fr_cnt - f0, 1);
        wr(lprtc_pkg::OFS_DIVIDER, 32'h0000_0005);
        rd_chk("divider locked", lprtc_pkg::OFS_DIVIDER, 32'h0000_0001);
        rd_chk("running", lprtc_pkg::OFS_STATUS, 32'h0000_0001);
    endtask
    // Stop freezes the count and frees the divider
    task automatic t_stop();
        wr(lprtc_pkg::OFS_TASK_STOP, 32'h0000_0001);
        poll("stopped", lprtc_pkg::OFS_STATUS, 32'h0000_0000);
        apb(1'b0, lprtc_pkg::OFS_COUNT, 32'h0000_0000, rd);
        repeat (40) @(posedge pclk);
        rd_chk("frozen count", lprtc_pkg::OFS_COUNT, rd);
        wr(lprtc_pkg::OFS_DIVIDER, 32'h0000_0000);
        rd_chk("divider free", lprtc_pkg::OFS_DIVIDER, 32'h0000_0000);
    endtask
    // Near wrap load from a parked slow clock, then wrap
    task automatic t_wrap();
        for (int n = 0; n < 4; n++) wr(lprtc_pkg::OFS_MATCH0 + 12'(4 * n), 32'h0000_0000);
        wr(lprtc_pkg::OFS_TASK_NEAR, 32'h0000_0001);
        poll("near wrap", lprtc_pkg::OFS_COUNT, 32'h00FF_FFF0);
        n0 = ev_cnt[0];
        wr(lprtc_pkg::OFS_TASK_START, 32'h0000_0001);
        wait_ev(lprtc_pkg::EV_WRAP, ev_cnt[1] + 1, 400);
        chk("ticks to wrap", ev_cnt[0] - n0, 16);
        rd_chk("wrap flag", lprtc_pkg::OFS_EV_WRAP, 32'h0000_0001);
        wr(lprtc_pkg::OFS_EV_WRAP, 32'h0000_0000);
        rd_chk("wrap flag", lprtc_pkg::OFS_EV_WRAP, 32'h0000_0000);
        for (int n = 0; n < 4; n++) begin
            rd_chk("compare flag", lprtc_pkg::OFS_EV_CMP0 + 12'(4 * n), {31'h0000_0000, n < 3});
            wr(lprtc_pkg::OFS_EV_CMP0 + 12'(4 * n), 32'h0000_0000);
        end
    endtask
    // Clear, start at match, match two ahead, unrouted channel
    task automatic t_compare();
        wr(lprtc_pkg::OFS_TASK_STOP, 32'h0000_0001);
        poll("stopped", lprtc_pkg::OFS_STATUS, 32'h0000_0000);
        n0 = ev_cnt[2];
        wr(lprtc_pkg::OFS_TASK_CLEAR, 32'h0000_0001);
        poll("cleared", lprtc_pkg::OFS_COUNT, 32'h0000_0000);
        rd_chk("clear flag", lprtc_pkg::OFS_EV_CMP0, 32'h0000_0000);
        chk("clear pulses", ev_cnt[2] - n0, 0);
        wr(lprtc_pkg::OFS_MATCH0 + 12'h004, 32'h0000_0002);
        wr(lprtc_pkg::OFS_MATCH0 + 12'h00C, 32'h0000_0002);
        n0 = ev_cnt[4];
        wr(lprtc_pkg::OFS_TASK_START, 32'h0000_0001);
        wait_ev(lprtc_pkg::EV_CMP + 1, ev_cnt[3] + 1, 200);
        wait_ev(lprtc_pkg::EV_TICK, ev_cnt[0] + 2, 60);
        rd_chk("match two ahead", lprtc_pkg::OFS_EV_CMP0 + 12'h004, 32'h0000_0001);
        rd_chk("start at match", lprtc_pkg::OFS_EV_CMP0 + 12'h008, 32'h0000_0000);
        chk("start pulses", ev_cnt[4] - n0, 0);
        rd_chk("unrouted flag", lprtc_pkg::OFS_EV_CMP0 + 12'h00C, 32'h0000_0000);
        chk("unrouted pulses", ev_cnt[5], 0);
        // Old match far ahead, replaced before reached
        apb(1'b0, lprtc_pkg::OFS_COUNT, 32'h0000_0000, rd);
        n0 = ev_cnt[2];
        wr(lprtc_pkg::OFS_MATCH0, rd + 32'h0000_0004);
        wr(lprtc_pkg::OFS_MATCH0, 32'h00FF_0000);
        wait_ev(lprtc_pkg::EV_TICK, ev_cnt[0] + 6, 130);
        chk("old match pulses", ev_cnt[2] - n0, 0);
        rd_chk("old match flag", lprtc_pkg::OFS_EV_CMP0, 32'h0000_0000);
    endtask

    // Main sequence
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_route();
        t_rate();
        t_stop();
        t_wrap();
        t_compare();
        finish_test();
    end
endmodule
